// File: src/adc_ctrl_pkg.sv
// shared constants for the converter control port and its output fifo
package adc_ctrl_pkg;
   localparam int WORD_BITS = 32;        // bits in one serial frame
   localparam int HALF_BITS = 16;        // address half and data half of a write
   localparam int DEC_RATIO_HI = 128;    // ratio when decimation_select is high
   localparam int DEC_RATIO_LO = 256;    // ratio when decimation_select is low
   localparam int DEC_CNT_BITS = 9;      // wide enough for the larger ratio
   localparam logic [1:0] MOD_DIV_NORMAL = 2'h1; // last divider count, master clock / 2
   localparam logic [1:0] MOD_DIV_LOW = 2'h3;    // last divider count, master clock / 4
   localparam int FIFO_DEPTH = 8;        // output words buffered
   localparam int SYNC_STAGES = 3;       // flip-flops on every pin input
   localparam int PIN_LAT = 4;           // cycles from pin to filtered level
   localparam int CONV_BITS = 24;        // converted sample width
   // pin index inside the synchroniser vector
   localparam int PIN_WFS = 0;
   localparam int PIN_WDI = 1;
   localparam int PIN_SYNC = 2;
   localparam int PIN_PD = 3;
   localparam int PIN_DEC = 4;
   localparam int PIN_CNT = 5;
   localparam logic [PIN_CNT-1:0] PIN_RST = 5'h00; // reset level of all pin stages
   // serializer and write receiver states
   typedef enum logic [0:0] {S_IDLE = 1'b0, S_SHIFT = 1'b1} shift_state_e;
endpackage

// File: src/word_fifo.sv
// flip-flop fifo with valid/ready on both sides
module word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_clear,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];   // storage words
   logic [AW-1:0] wr_ptr_r, wr_ptr_nxt; // next slot to fill
   logic [AW-1:0] rd_ptr_r, rd_ptr_nxt; // oldest slot
   logic [AW:0] count_r, count_nxt;     // words held
   logic push, pop;

   // honest flags: full refuses, empty shows no data
   assign o_in_ready = (count_r != DEPTH[AW:0]);
   assign o_out_valid = (count_r != '0);
   assign o_out_data = mem_r[rd_ptr_r];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   // pointer and count update, wrap at depth
   always_comb begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      count_nxt = count_r;
      if (i_clear) begin
         wr_ptr_nxt = '0;
         rd_ptr_nxt = '0;
         count_nxt = '0;
      end else begin
         if (push) begin
            wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // pointer registers
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r <= count_nxt;
      end
   end

   // data storage, written only on an accepted push
   always_ff @(posedge i_sys_clk) begin
      if (push && !i_clear) begin
         mem_r[wr_ptr_r] <= i_in_data;
      end
   end
endmodule

// File: src/adc_serial_control_port.sv
// control port of a sigma-delta converter: clocks, decimation, serial in/out
//
// Behaviour
// [RULE1] host gives msb at first falling edge
// [RULE2] each write is exactly thirty-two bits
// [RULE3] first half address, second half data
// [RULE4] frame sync sampled on each falling edge
// [RULE5] sync low: first bit on next fall
// [RULE6] sync pin falling edge resets the filter
// [RULE7] reset pin low holds everything in reset
// [RULE8] select high gives decimation of 128
// [RULE9] select low gives decimation of 256
// [RULE10] output word rate follows master clock
// [RULE11] serial clock equals modulator clock rate
// [RULE12] output frame sync low for 32 periods
// [RULE13] output bits launched on serial clock rise
// [RULE14] modulator clock is master over two/four
// [RULE15] host sends remaining bits msb first
module adc_serial_control_port (
   input wire logic i_sys_clk,                    // master clock
   input wire logic i_rstn,                       // asynchronous reset
   input wire logic i_low_power,                  // low power mode, same clock domain
   input wire logic [adc_ctrl_pkg::CONV_BITS-1:0] i_conv_data, // filter result
   input wire logic i_write_frame_sync,           // pin, active low frame start
   input wire logic i_serial_write_input,         // pin, write data
   input wire logic i_filter_sync,                // pin, falling edge aligns filter
   input wire logic i_reset_powerdown_n,          // pin, low powers down
   input wire logic i_decimation_select,          // pin, high 128, low 256
   output logic o_serial_clock_out,               // serial clock
   output logic o_output_frame_sync_n,            // output frame, active low
   output logic o_serial_read_output,             // output data
   output logic [adc_ctrl_pkg::HALF_BITS-1:0] o_write_addr, // device and register address
   output logic [adc_ctrl_pkg::HALF_BITS-1:0] o_write_data, // value written
   output logic o_write_valid,                    // one-cycle pulse per write
   output logic o_filter_reset,                   // one-cycle filter reset pulse
   output logic o_powered_down                    // power-down state
);
   import adc_ctrl_pkg::*;

   logic [PIN_CNT-1:0] s1_r, s2_r, s3_r;   // pin synchroniser stages
   logic [PIN_CNT-1:0] filt_r, filt_nxt;   // agreed pin levels
   logic pd;                               // power-down active
   logic [1:0] div_r, div_nxt;             // modulator clock divider
   logic [1:0] div_last, div_half;         // divider wrap and half point
   logic sck_r, sck_nxt;                   // serial clock level
   logic rise_ev, fall_ev;                 // serial clock edges at this edge
   logic [PIN_LAT-1:0] fall_dly_r, fall_dly_nxt; // falls aligned to pin latency
   logic sync_prev_r, sync_fall;           // filter sync edge detect
   logic [DEC_CNT_BITS-1:0] dec_cnt_r, dec_cnt_nxt; // modulator samples counted
   logic [DEC_CNT_BITS-1:0] dec_last;      // last count of a conversion
   logic conv_pend_r, conv_pend_nxt;       // word waiting for the fifo
   logic [WORD_BITS-1:0] conv_word_r, conv_word_nxt;
   logic fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [WORD_BITS-1:0] fifo_out_data;
   shift_state_e ser_state_r, ser_state_nxt;
   logic [WORD_BITS-1:0] out_sh_r, out_sh_nxt;     // output shifter
   logic [4:0] out_cnt_r, out_cnt_nxt;             // output bits sent
   logic ofs_n_r, ofs_n_nxt, rdo_r, rdo_nxt; // output frame and read bit
   shift_state_e wr_state_r, wr_state_nxt;
   logic [WORD_BITS-1:0] in_sh_r, in_sh_nxt;       // input shifter
   logic [4:0] in_cnt_r, in_cnt_nxt;               // input bits taken
   logic [WORD_BITS-1:0] wr_word_r, wr_word_nxt;
   logic wr_valid_r, wr_valid_nxt, frst_r, frst_nxt;

   // pin synchroniser: three stages, level moves once stages two and three agree
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s1_r <= PIN_RST;
         s2_r <= PIN_RST;
         s3_r <= PIN_RST;
         filt_r <= PIN_RST;
      end else begin
         s1_r <= {i_decimation_select, i_reset_powerdown_n, i_filter_sync,
                  i_serial_write_input, i_write_frame_sync};
         s2_r <= s1_r;
         s3_r <= s2_r;
         filt_r <= filt_nxt;
      end
   end

   // agreement filter on the last two stages
   always_comb begin
      filt_nxt = (s2_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));
   end

   assign pd = !filt_r[PIN_PD];  // [RULE7]
   assign div_last = i_low_power ? MOD_DIV_LOW : MOD_DIV_NORMAL;  // [RULE14]
   // widened first: in two bits 3 + 1 wraps to zero and the clock would stick low
   assign div_half = 2'((3'(div_last) + 3'h1) >> 1);
   assign rise_ev = !pd && (div_r >= div_last);
   assign fall_ev = !pd && (div_r == div_half - 2'h1);
   assign sync_fall = sync_prev_r && !filt_r[PIN_SYNC];
   assign dec_last = filt_r[PIN_DEC] ? DEC_CNT_BITS'(DEC_RATIO_HI - 1)  // [RULE8]
                                     : DEC_CNT_BITS'(DEC_RATIO_LO - 1); // [RULE9]
   assign fifo_pop = rise_ev && (ser_state_r == S_IDLE);

   // modulator clock divider and serial clock, one serial period per modulator period
   always_comb begin
      div_nxt = rise_ev ? 2'h0 : div_r + 2'h1;           // [RULE14]
      if (pd) begin
         div_nxt = 2'h0;
      end
      sck_nxt = !pd && (div_nxt < div_half);              // [RULE11]
      fall_dly_nxt = {fall_dly_r[PIN_LAT-2:0], fall_ev};  // [RULE4]
      if (pd) begin
         fall_dly_nxt = '0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         div_r <= 2'h0;
         sck_r <= 1'b0;
         fall_dly_r <= '0;
         sync_prev_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         sck_r <= sck_nxt;
         fall_dly_r <= fall_dly_nxt;
         sync_prev_r <= filt_r[PIN_SYNC];
      end
   end

   // decimation: one output word per ratio of modulator samples
   always_comb begin
      dec_cnt_nxt = dec_cnt_r;
      conv_pend_nxt = conv_pend_r && !fifo_in_ready;
      conv_word_nxt = conv_word_r;
      frst_nxt = 1'b0;
      if (pd) begin
         dec_cnt_nxt = '0;                                // [RULE7]
         conv_pend_nxt = 1'b0;
      end else if (sync_fall) begin
         dec_cnt_nxt = '0;                                // [RULE6]
         conv_pend_nxt = 1'b0;
         frst_nxt = 1'b1;
      end else if (rise_ev) begin
         if (dec_cnt_r >= dec_last) begin                 // [RULE10]
            dec_cnt_nxt = '0;
            conv_pend_nxt = 1'b1;
            conv_word_nxt = {i_conv_data, filt_r[PIN_DEC], i_low_power, 6'h00};
         end else begin
            dec_cnt_nxt = dec_cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dec_cnt_r <= '0;
         conv_pend_r <= 1'b0;
         conv_word_r <= '0;
         frst_r <= 1'b0;
      end else begin
         dec_cnt_r <= dec_cnt_nxt;
         conv_pend_r <= conv_pend_nxt;
         conv_word_r <= conv_word_nxt;
         frst_r <= frst_nxt;
      end
   end

   // output words wait here until the serializer is free
   word_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_out_fifo (
      .i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn),
      .i_clear(pd || sync_fall),
      .i_in_valid(conv_pend_r),
      .o_in_ready(fifo_in_ready),
      .i_in_data(conv_word_r),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(fifo_pop),
      .o_out_data(fifo_out_data)
   );

   // serializer: launch on serial clock rise, frame low for 32 periods
   always_comb begin
      ser_state_nxt = ser_state_r;
      out_sh_nxt = out_sh_r;
      out_cnt_nxt = out_cnt_r;
      ofs_n_nxt = ofs_n_r;
      rdo_nxt = rdo_r;
      if (pd) begin
         ser_state_nxt = S_IDLE;
         ofs_n_nxt = 1'b1;
         rdo_nxt = 1'b0;
         out_cnt_nxt = '0;
      end else if (rise_ev) begin
         unique case (ser_state_r)
            S_IDLE: begin
               if (fifo_out_valid) begin
                  ser_state_nxt = S_SHIFT;
                  out_sh_nxt = {fifo_out_data[WORD_BITS-2:0], 1'b0};
                  rdo_nxt = fifo_out_data[WORD_BITS-1];   // [RULE13]
                  ofs_n_nxt = 1'b0;
                  out_cnt_nxt = '0;
               end
            end
            S_SHIFT: begin
               if (out_cnt_r == 5'(WORD_BITS - 1)) begin
                  ser_state_nxt = S_IDLE;                 // [RULE12]
                  ofs_n_nxt = 1'b1;
                  rdo_nxt = 1'b0;
               end else begin
                  rdo_nxt = out_sh_r[WORD_BITS-1];        // [RULE13]
                  out_sh_nxt = {out_sh_r[WORD_BITS-2:0], 1'b0};
                  out_cnt_nxt = out_cnt_r + 5'h01;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ser_state_r <= S_IDLE;
         out_sh_r <= '0;
         out_cnt_r <= '0;
         ofs_n_r <= 1'b1;
         rdo_r <= 1'b0;
      end else begin
         ser_state_r <= ser_state_nxt;
         out_sh_r <= out_sh_nxt;
         out_cnt_r <= out_cnt_nxt;
         ofs_n_r <= ofs_n_nxt;
         rdo_r <= rdo_nxt;
      end
   end

   // write receiver, acting on falls delayed by the pin latency
   always_comb begin
      wr_state_nxt = wr_state_r;
      in_sh_nxt = in_sh_r;
      in_cnt_nxt = in_cnt_r;
      wr_word_nxt = wr_word_r;
      wr_valid_nxt = 1'b0;
      if (pd) begin
         wr_state_nxt = S_IDLE;
         in_cnt_nxt = '0;
      end else if (fall_dly_r[PIN_LAT-1]) begin
         unique case (wr_state_r)
            S_IDLE: begin
               if (!filt_r[PIN_WFS]) begin                // [RULE4]
                  wr_state_nxt = S_SHIFT;                 // [RULE5]
                  in_cnt_nxt = '0;
               end
            end
            S_SHIFT: begin
               in_sh_nxt = {in_sh_r[WORD_BITS-2:0], filt_r[PIN_WDI]}; // [RULE1] [RULE15]
               in_cnt_nxt = in_cnt_r + 5'h01;
               if (in_cnt_r == 5'(WORD_BITS - 1)) begin   // [RULE2]
                  wr_state_nxt = S_IDLE;
                  wr_word_nxt = in_sh_nxt;                // [RULE3]
                  wr_valid_nxt = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_state_r <= S_IDLE;
         in_sh_r <= '0;
         in_cnt_r <= '0;
         wr_word_r <= '0;
         wr_valid_r <= 1'b0;
      end else begin
         wr_state_r <= wr_state_nxt;
         in_sh_r <= in_sh_nxt;
         in_cnt_r <= in_cnt_nxt;
         wr_word_r <= wr_word_nxt;
         wr_valid_r <= wr_valid_nxt;
      end
   end

   assign o_serial_clock_out = sck_r;
   assign o_output_frame_sync_n = ofs_n_r;
   assign o_serial_read_output = rdo_r;
   assign o_write_addr = wr_word_r[WORD_BITS-1:HALF_BITS];
   assign o_write_data = wr_word_r[HALF_BITS-1:0];
   assign o_write_valid = wr_valid_r;
   assign o_filter_reset = frst_r;
   assign o_powered_down = pd;

   // checks
   property p_ofs_end;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      $rose(o_output_frame_sync_n) && !$past(pd) |-> $past(out_cnt_r) == 5'h1f;
   endproperty
   a_ofs_end: assert property (p_ofs_end) else $error("frame ended early"); // RULE12

   // normal mode must hold over the whole period: a switch inside it stretches the period
   property p_sck_rate;
      @(posedge i_sys_clk) disable iff (!i_rstn || pd)
      ($rose(sck_r) && !i_low_power) ##1 !i_low_power ##1 !i_low_power |-> $rose(sck_r);
   endproperty
   a_sck_rate: assert property (p_sck_rate) else $error("serial clock rate wrong"); // RULE11

   property p_rdo_launch;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      $changed(o_serial_read_output) && !pd |-> $rose(o_serial_clock_out);
   endproperty
   a_rdo_launch: assert property (p_rdo_launch) else $error("data off rising edge"); // RULE13

   property p_frame_start;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      fall_dly_r[PIN_LAT-1] && !pd && wr_state_r == S_IDLE && !filt_r[PIN_WFS]
      |=> wr_state_r == S_SHIFT && in_cnt_r == 5'h00;
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("frame sync missed"); // RULE5

   property p_write_len;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      o_write_valid |-> $past(in_cnt_r) == 5'h1f && $past(wr_state_r) == S_SHIFT;
   endproperty
   a_write_len: assert property (p_write_len) else $error("write not 32 bits"); // RULE2

   property p_write_split;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      o_write_valid |-> {o_write_addr, o_write_data} ==
         {$past(in_sh_r[WORD_BITS-2:0]), $past(filt_r[PIN_WDI])};
   endproperty
   a_write_split: assert property (p_write_split) else $error("write word split wrong"); // RULE3

   property p_sync_reset;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      sync_fall && !pd |=> dec_cnt_r == '0 && o_filter_reset;
   endproperty
   a_sync_reset: assert property (p_sync_reset) else $error("filter not reset"); // RULE6

   property p_powerdown;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      pd |=> ser_state_r == S_IDLE && wr_state_r == S_IDLE && o_output_frame_sync_n
             && !o_serial_clock_out;
   endproperty
   a_powerdown: assert property (p_powerdown) else $error("logic not held in reset"); // RULE7
endmodule

// File: tb/host_write_model.sv
// host side model that shifts write frames into the converter pins
module host_write_model (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_sck,
   input wire logic i_start,
   input wire logic [31:0] i_word,
   output logic o_wfs,
   output logic o_wdi,
   output logic o_taken
);
   timeunit 1ns;
   timeprecision 1ns;
   logic sck_q; // serial clock seen one cycle ago
   logic [31:0] word_r; // frame being sent
   int cnt; // 0 idle, 1..32 next bit index, 33 last bit shown

   // pins change one cycle after a serial clock fall, so they stand still across the next fall
   always @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sck_q <= 1'b0;
         o_wfs <= 1'b1;
         o_wdi <= 1'b0;
         o_taken <= 1'b0;
         word_r <= 32'h0;
         cnt <= 0;
      end else begin
         sck_q <= i_sck;
         o_taken <= 1'b0;
         if (sck_q && !i_sck) begin
            if ((cnt == 0 || cnt == 33) && i_start) begin
               // frame sync low, the msb follows on the next fall
               o_wfs <= 1'b0;
               o_wdi <= ~o_wdi;
               word_r <= i_word;
               o_taken <= 1'b1;
               cnt <= 1;
            end else if (cnt >= 1 && cnt <= 32) begin
               o_wfs <= 1'b1;
               o_wdi <= word_r[32-cnt]; // msb first, address half then data
               cnt <= cnt + 1; // thirty-two bits per write
            end else begin
               // released line shows a changing pattern, never the stale bit
               o_wdi <= ~o_wdi;
               cnt <= 0;
            end
         end
      end
   end
endmodule

// File: tb/testbench.sv
// self-checking testbench for the converter control port
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import adc_ctrl_pkg::*;
   logic sys_clk = 1'b0; // master clock
   logic rstn = 1'b0; // async reset
   logic low_power = 1'b0; // power mode
   logic [CONV_BITS-1:0] conv_data = 24'h5a3c96; // filter result
   logic sync_pin = 1'b1; // filter alignment pin
   logic pd_n = 1'b0; // power-down pin
   logic dec_sel = 1'b1; // decimation select pin
   logic wfs; // host frame sync
   logic wdi; // host data
   logic sck; // serial clock from the device
   logic ofs_n; // output frame, active low
   logic rdo; // output data bit
   logic wr_valid;
   logic filt_rst;
   logic pd;
   logic [HALF_BITS-1:0] wr_addr;
   logic [HALF_BITS-1:0] wr_data;
   logic host_start = 1'b0; // ask the host model for a frame
   logic [31:0] host_word = 32'h0; // frame for the host model
   logic host_taken;
   int fail_count = 0;
   int total_checks = 0;
   logic [31:0] writes[$]; // completed writes seen at the ports
   int filt_pulses = 0; // filter reset pulses seen

   // clock of 20 ns
   always #10 sys_clk = ~sys_clk;

   adc_serial_control_port u_dut (
      .i_sys_clk(sys_clk), .i_rstn(rstn), .i_low_power(low_power),
      .i_conv_data(conv_data), .i_write_frame_sync(wfs), .i_serial_write_input(wdi),
      .i_filter_sync(sync_pin), .i_reset_powerdown_n(pd_n),
      .i_decimation_select(dec_sel), .o_serial_clock_out(sck),
      .o_output_frame_sync_n(ofs_n), .o_serial_read_output(rdo),
      .o_write_addr(wr_addr), .o_write_data(wr_data), .o_write_valid(wr_valid),
      .o_filter_reset(filt_rst), .o_powered_down(pd)
   );

   host_write_model u_host (
      .i_sys_clk(sys_clk), .i_rstn(rstn), .i_sck(sck), .i_start(host_start),
      .i_word(host_word), .o_wfs(wfs), .o_wdi(wdi), .o_taken(host_taken)
   );

   // collect writes and filter pulses where outputs are settled
   always @(negedge sys_clk) begin
      if (wr_valid === 1'b1) begin
         writes.push_back({wr_addr, wr_data});
      end
      if (filt_rst === 1'b1) begin
         filt_pulses++;
      end
   end

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic timeout(input string name);
      fail_count++;
      $display("CHECK FAILED %s expected done seen timeout", name);
      results();
   endtask

   // one settled cycle with a bound on the whole wait
   task automatic step(inout int t);
      @(negedge sys_clk);
      t++;
      if (t > 3000) begin
         timeout("wait bound");
      end
   endtask

   task automatic wait_sck(input logic lvl);
      int n;
      n = 0;
      step(n);
      while (sck !== lvl) step(n);
   endtask

   task automatic wait_up();
      int n;
      n = 0;
      while (pd !== 1'b0) step(n);
      check("powered up", 0, pd);
   endtask

   // count high and low cycles of one serial clock period
   task automatic measure_sck(input int half);
      int hi;
      int lo;
      hi = 0;
      lo = 0;
      wait_sck(0);
      wait_sck(1);
      while (sck === 1'b1 && hi < 10) begin
         hi++;
         @(negedge sys_clk);
      end
      while (sck === 1'b0 && lo < 10) begin
         lo++;
         @(negedge sys_clk);
      end
      check("serial clock high cycles", half, hi);
      check("serial clock low cycles", half, lo);
   endtask

   // returns at the first cycle of the next output frame
   task automatic wait_frame(output int t);
      t = 0;
      while (ofs_n !== 1'b1) step(t);
      while (ofs_n !== 1'b0) step(t);
   endtask

   task automatic frame_gap(input int exp);
      int t;
      wait_frame(t);
      wait_frame(t);
      wait_frame(t);
      check("frame spacing", exp, t);
   endtask

   // sample output bits on serial falls while the frame is low
   task automatic read_frame(input logic [31:0] exp);
      int t;
      int bits;
      logic [31:0] w;
      logic prev;
      bits = 0;
      w = 32'h0;
      wait_frame(t);
      prev = sck;
      while (ofs_n === 1'b0) begin
         step(t);
         if (prev === 1'b1 && sck === 1'b0 && ofs_n === 1'b0) begin
            w = {w[30:0], rdo};
            bits++;
         end
         prev = sck;
      end
      check("frame bits", 32, bits);
      check("frame word", exp, w);
   endtask

   task automatic host_write(input logic [31:0] w);
      int n;
      n = 0;
      @(posedge sys_clk);
      host_word <= w;
      host_start <= 1'b1;
      step(n);
      while (host_taken !== 1'b1) step(n);
   endtask

   // two frames back to back, the second sync right after the last bit
   task automatic write_scenario(input logic [31:0] a, input logic [31:0] b);
      int n;
      writes.delete();
      host_write(a);
      host_write(b);
      @(posedge sys_clk);
      host_start <= 1'b0;
      n = 0;
      while (writes.size() < 2) step(n);
      repeat (300) @(negedge sys_clk);
      check("write count", 2, writes.size());
      check("first write", a, writes[0]);
      check("second write", b, writes[1]);
   endtask

   // only a falling edge of the alignment pin resets the filter
   task automatic filter_scenario();
      filt_pulses = 0;
      @(posedge sys_clk);
      sync_pin <= 1'b0;
      repeat (20) @(posedge sys_clk);
      check("filter pulses after fall", 1, filt_pulses);
      sync_pin <= 1'b1;
      repeat (20) @(posedge sys_clk);
      check("filter pulses after rise", 1, filt_pulses);
   endtask

   task automatic powerdown_scenario();
      int n;
      @(posedge sys_clk);
      pd_n <= 1'b0;
      repeat (10) @(posedge sys_clk);
      check("powered down", 1, pd);
      n = 0;
      repeat (600) begin
         @(negedge sys_clk);
         // no frame and no serial clock while powered down
         if (ofs_n !== 1'b1 || sck !== 1'b0) begin
            n++;
         end
      end
      check("frame cycles while down", 0, n);
      @(posedge sys_clk);
      pd_n <= 1'b1;
      wait_up();
   endtask

   // main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      check("powered down in reset", 1, pd);
      check("frame sync in reset", 1, ofs_n);
      rstn <= 1'b1;
      @(posedge sys_clk);
      pd_n <= 1'b1;
      wait_up();
      measure_sck(1);
      write_scenario(32'h1234abcd, 32'hfedc0001);
      read_frame({conv_data, 1'b1, 1'b0, 6'h00});
      frame_gap(256);
      @(posedge sys_clk);
      dec_sel <= 1'b0;
      frame_gap(512);
      read_frame({conv_data, 1'b0, 1'b0, 6'h00});
      @(posedge sys_clk);
      low_power <= 1'b1;
      dec_sel <= 1'b1;
      frame_gap(512);
      measure_sck(2);
      write_scenario(32'h0000ffff, 32'h80017ffe);
      filter_scenario();
      powerdown_scenario();
      results();
   end
endmodule
